//--- verilog/adccr_ctrl.sv
// Converter cycle control, speed selection and 32-bit serial result readout
//
// Notes on behaviour
// - Config input low selects fast setting
// - Config input high selects ultralow-noise setting
// - Level change applies after next data output
// - Serial selection word picks one of ten
// - Source select low: shift clock is input
// - Source select high: device drives shift clock
// - Select low enables output and wakes
// - Sleep after conversion while select high
// - Select rising during output aborts, reconverts
// - Select high keeps result output released
// - Status on output during conversion, sleep
// - Internal oscillator sets conversion time
// - External conversion clock sets conversion time
// - Busy high converting, low until restart
// - Fixed cycle: convert, sleep, output
// - Sleep holds result in shift register
// - Output starts with just-finished result
// - Output changes on falling shift clock
// - Output ends after 32 bits or deselect
// - Calibration inside every conversion, timing unchanged
// - Power-on clear about 0.5 ms
// - Word: done, filler, sign, result, sub-bits
// - Done flag high converting, low when done
// - Sign and MSB flag out of range
// - Output high after 32nd falling edge
`timescale 1ns/100ps
module adccr_ctrl
  import adccr_pkg::*;
#(
  parameter int unsigned POR_LEN = POR_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_serial_cfg_in,
  input wire logic i_clock_source_sel,
  input wire logic i_conv_clock_pin,
  input wire logic i_sck,
  input wire logic [RESULT_BITS-1:0] i_conv_result,
  output logic o_sck,
  output logic o_sck_oe,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  output logic o_busy,
  output logic o_calibrating,
  output logic [3:0] o_speed_sel
);

  // Two-flop synchronisers for all pin inputs; only stage two is read
  // Reset to the idle pin levels so that no false edge follows reset
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic sck_d1_q;
  logic conv_pin_d1_q;
  logic cs_n_d1_q;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end
    else
    begin
      sync1_q <= {i_cs_n, i_serial_cfg_in, i_clock_source_sel, i_conv_clock_pin, i_sck};
      sync2_q <= sync1_q;
    end
  end

  wire cs_n_s = sync2_q[4];
  wire cfg_s = sync2_q[3];
  wire ext_sck_mode = sync2_q[2];
  wire conv_pin_s = sync2_q[1];
  wire sck_in_s = sync2_q[0];

  // Delayed copies for edge detection of the synchronised levels
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sck_d1_q <= 1'b0;
      conv_pin_d1_q <= 1'b0;
      cs_n_d1_q <= 1'b1;
    end
    else
    begin
      sck_d1_q <= sck_in_s;
      conv_pin_d1_q <= conv_pin_s;
      cs_n_d1_q <= cs_n_s;
    end
  end

  // Edges of the synchronised select and conversion clock pin
  wire cs_rise = cs_n_s & ~cs_n_d1_q;
  wire conv_pin_rise = conv_pin_s & ~conv_pin_d1_q;

  // Cycle state, counters and the result shift register
  adccr_state_t state_q;
  logic [31:0] por_cnt_q;
  logic [31:0] osc_acc_q;
  logic osc_tick_q;
  logic [EXT_TMO_W-1:0] ext_tmo_q;
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic [CONV_CNT_W-1:0] conv_len_q;
  logic [3:0] speed_q;
  logic [3:0] sel_word_q;
  logic [2:0] sel_cnt_q;
  logic [WORD_BITS-1:0] shreg_q;
  logic [5:0] bit_cnt_q;
  logic [2:0] isck_tick_q;
  logic isck_q;
  logic sdo_q;

  // Internal 9 MHz oscillator as a one-cycle enable from a phase accumulator
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      osc_acc_q <= 32'h0;
      osc_tick_q <= 1'b0;
    end
    else
    begin
      {osc_tick_q, osc_acc_q} <= {1'b0, osc_acc_q} + {1'b0, OSC_PHASE_STEP};
    end
  end

  // External clock is used while its edges keep arriving; a tied pin falls back
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ext_tmo_q <= '0;
    else if (conv_pin_rise)
      ext_tmo_q <= EXT_TMO_W'(EXT_TIMEOUT_CYCLES);
    else if (ext_tmo_q != '0)
      ext_tmo_q <= ext_tmo_q - 1'b1;
  end

  // Conversion tick: external edges while they arrive, otherwise the oscillator
  wire ext_osc_present = (ext_tmo_q != '0);
  wire conv_tick = ext_osc_present ? conv_pin_rise : osc_tick_q;

  // Internal shift clock edges and external shift clock edges merge here
  wire isck_edge = (state_q == ADCCR_OUT) && ext_sck_mode && !cs_n_s && conv_tick
                   && (isck_tick_q == ISCK_HALF_TICKS - 3'h1);
  wire sck_rise = ext_sck_mode ? (isck_edge && !isck_q) : (sck_in_s && !sck_d1_q);
  wire sck_fall = ext_sck_mode ? (isck_edge && isck_q) : (!sck_in_s && sck_d1_q);
  wire out_done = (state_q == ADCCR_OUT) && sck_fall && (bit_cnt_q == LAST_BIT_CNT - 6'h1);
  wire out_abort = (state_q == ADCCR_OUT) && cs_rise;
  wire conv_done = (state_q == ADCCR_CONV) && conv_tick && (conv_cnt_q + 1'b1 >= conv_len_q);
  wire por_done = (state_q == ADCCR_POR) && (por_cnt_q >= POR_LEN - 1);

  // Ratio for a speed index, and the tick count of one conversion
  function automatic logic [CONV_CNT_W-1:0] adccr_conv_len(input logic [3:0] idx);
    logic [CONV_CNT_W-1:0] oversample_ratio;
    oversample_ratio = OSR_BASE << idx;
    return CONV_CNT_W'(oversample_ratio * CONV_MULT) + CONV_OVERHEAD;
  endfunction : adccr_conv_len

  // Power-on clear counter
  // It only counts in the clear state, so it never wraps in a long run
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      por_cnt_q <= 32'h0;
    else if (state_q == ADCCR_POR)
      por_cnt_q <= por_cnt_q + 32'h1;
  end

  // Cycle sequencer: convert, sleep, output, back to convert
  // A deselect during output and the last falling edge both restart conversion
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_q <= ADCCR_POR;
    else
    begin
      case (state_q)
        ADCCR_POR:
          if (por_done)
            state_q <= ADCCR_CONV;
        ADCCR_CONV:
          if (conv_done)
            state_q <= ADCCR_SLEEP;
        ADCCR_SLEEP:
          if (!cs_n_s)
            state_q <= ADCCR_OUT;
        ADCCR_OUT:
          if (out_abort || out_done)
            state_q <= ADCCR_CONV;
        default:
          state_q <= ADCCR_POR;
      endcase
    end
  end

  // Speed chosen at each conversion start: a fresh serial word of 1 to 10 wins over the level
  wire sel_valid = (sel_cnt_q == 3'(SEL_BITS)) && (sel_word_q != 4'h0)
                   && (sel_word_q <= 4'(NUM_SPEEDS));
  wire [3:0] next_speed = sel_valid ? (sel_word_q - 4'h1) : (cfg_s ? SPEED_QUIET : SPEED_FAST);
  wire conv_start = por_done || out_abort || out_done;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      speed_q <= SPEED_FAST;
      conv_len_q <= '0;
      conv_cnt_q <= '0;
    end
    // Length worked out once per conversion keeps the end compare narrow
    else if (conv_start)
    begin
      speed_q <= next_speed;
      conv_len_q <= adccr_conv_len(next_speed);
      conv_cnt_q <= '0;
    end
    else if (state_q == ADCCR_CONV && conv_tick)
      conv_cnt_q <= conv_cnt_q + 1'b1;
  end

  // Selection word captured MSB first on rising shift clock during output
  // Limitation: only the first four rising edges of a frame count
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sel_word_q <= 4'h0;
      sel_cnt_q <= 3'h0;
    end
    else if (state_q == ADCCR_SLEEP)
    begin
      sel_word_q <= 4'h0;
      sel_cnt_q <= 3'h0;
    end
    else if (state_q == ADCCR_OUT && sck_rise && sel_cnt_q < 3'(SEL_BITS))
    begin
      sel_word_q <= {sel_word_q[2:0], cfg_s};
      sel_cnt_q <= sel_cnt_q + 3'h1;
    end
  end

  // Internal shift clock generator, idle low, runs only while reading out
  // Stops whenever the frame is cut, so every frame starts with a rising edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      isck_q <= 1'b0;
      isck_tick_q <= 3'h0;
    end
    else if (state_q != ADCCR_OUT || cs_n_s || !ext_sck_mode)
    begin
      isck_q <= 1'b0;
      isck_tick_q <= 3'h0;
    end
    else if (conv_tick)
    begin
      if (isck_edge)
      begin
        isck_q <= ~isck_q;
        isck_tick_q <= 3'h0;
      end
      else
        isck_tick_q <= isck_tick_q + 3'h1;
    end
  end

  // Result word: loaded at conversion end, frozen in sleep, shifted on falling edges
  // Ones shift in behind the word, matching the level shown after the last bit
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      shreg_q <= '0;
      bit_cnt_q <= 6'h0;
    end
    else if (conv_done)
    begin
      shreg_q <= {1'b0, 1'b0, i_conv_result};
      bit_cnt_q <= 6'h0;
    end
    else if (state_q == ADCCR_OUT && sck_fall)
    begin
      shreg_q <= {shreg_q[WORD_BITS-2:0], 1'b1};
      bit_cnt_q <= bit_cnt_q + 6'h1;
    end
  end

  // Output bit: status in convert and sleep, word bits in output
  // Conversion start has priority so the high level after the last bit is never lost
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sdo_q <= 1'b1;
    else if (conv_start)
      sdo_q <= 1'b1;
    else if (conv_done)
      sdo_q <= 1'b0;
    else if (state_q == ADCCR_OUT && sck_fall)
      sdo_q <= shreg_q[WORD_BITS-2];
    else if (state_q == ADCCR_SLEEP)
      sdo_q <= shreg_q[DONE_BIT];
  end

  // Pin drivers; result line released while deselected to share the bus
  // Enables follow the synchronised pins, a few cycles behind them
  assign o_serial_result_out = sdo_q;
  assign o_serial_result_oe = !cs_n_s;
  assign o_sck = isck_q;
  assign o_sck_oe = ext_sck_mode;
  assign o_busy = (state_q == ADCCR_CONV) || (state_q == ADCCR_POR);
  // Calibration uses the fixed overhead ticks at the end of each conversion
  assign o_calibrating = (state_q == ADCCR_CONV) && (conv_cnt_q + CONV_OVERHEAD >= conv_len_q);
  assign o_speed_sel = speed_q;

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Sequencing checks
  busy_fall_a: assert property ($fell(o_busy) |-> $past(conv_done))
    else $error("busy fell without a finished conversion");
  sleep_hold_a: assert property ((state_q == ADCCR_SLEEP) ##1 (state_q == ADCCR_SLEEP) |-> $stable(shreg_q))
    else $error("result changed during sleep");
  abort_restart_a: assert property (out_abort |=> state_q == ADCCR_CONV && o_busy)
    else $error("deselect did not restart conversion");
  last_bit_a: assert property (out_done |=> o_serial_result_out && state_q == ADCCR_CONV)
    else $error("output not high after last bit");
  done_flag_a: assert property (conv_done |=> !o_serial_result_out && state_q == ADCCR_SLEEP)
    else $error("done flag not low at conversion end");
  cycle_order_a: assert property ((state_q == ADCCR_CONV) ##1 (state_q != ADCCR_CONV) |-> state_q == ADCCR_SLEEP)
    else $error("conversion not followed by sleep");
  stay_asleep_a: assert property ((state_q == ADCCR_SLEEP && cs_n_s) |=> state_q == ADCCR_SLEEP)
    else $error("woke while deselected");
  out_length_a: assert property ((state_q == ADCCR_OUT) |-> (bit_cnt_q < LAST_BIT_CNT))
    else $error("output ran past the last bit");

  // Pin and speed checks
  result_release_a: assert property (cs_n_s |-> !o_serial_result_oe)
    else $error("result line driven while deselected");
  speed_apply_a: assert property (conv_start |=> o_speed_sel == $past(next_speed))
    else $error("speed not applied at conversion start");
  speed_range_a: assert property (o_speed_sel < 4'(NUM_SPEEDS))
    else $error("speed index out of range");
  sck_idle_a: assert property ((o_sck_oe && state_q != ADCCR_OUT) |-> !o_sck)
    else $error("internal shift clock not idle outside output");

endmodule : adccr_ctrl

//--- verilog/adccr_pkg.sv
// Shared constants for the converter cycle and serial readout block
package adccr_pkg;

  // Idle levels of the synchronised pins {cs_n, cfg, source sel, conv pin, sck}
  localparam logic [4:0] SYNC_IDLE = 5'h10;

  // Main clock rate and derived figures
  localparam int unsigned REF_CLK_HZ = 125_000_000;
  localparam int unsigned POR_TIME_US = 500;
  localparam int unsigned POR_CYCLES = POR_TIME_US * (REF_CLK_HZ / 1_000_000);

  // Internal conversion oscillator, produced by a phase accumulator
  localparam int unsigned INT_OSC_HZ = 9_000_000;
  localparam logic [31:0] OSC_PHASE_STEP = 32'((64'(INT_OSC_HZ) << 32) / REF_CLK_HZ);

  // External conversion clock is deemed present while edges arrive within this time
  localparam int unsigned EXT_TIMEOUT_US = 20;
  localparam int unsigned EXT_TIMEOUT_CYCLES = EXT_TIMEOUT_US * (REF_CLK_HZ / 1_000_000);
  localparam int unsigned EXT_TMO_W = $clog2(EXT_TIMEOUT_CYCLES + 1);

  // Conversion length in conversion clock ticks: 40 * ratio + 170
  localparam logic [23:0] CONV_MULT = 24'h000028;
  localparam logic [23:0] CONV_OVERHEAD = 24'h0000aa;
  localparam int unsigned CONV_CNT_W = 24;

  // Speed settings: ten entries, ratio = 64 << index
  localparam int unsigned NUM_SPEEDS = 10;
  localparam logic [3:0] SPEED_FAST = 4'h2;
  localparam logic [3:0] SPEED_QUIET = 4'h9;
  localparam logic [23:0] OSR_BASE = 24'h000040;
  localparam int unsigned SEL_BITS = 4;

  // Internal shift clock: conversion clock / 10, so 5 ticks per half period
  localparam logic [2:0] ISCK_HALF_TICKS = 3'h5;

  // Output word layout
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned DONE_BIT = 31;
  localparam int unsigned FILLER_BIT = 30;
  localparam int unsigned SIGN_POS = 29;
  localparam int unsigned RESULT_BITS = 30;
  localparam logic [5:0] LAST_BIT_CNT = 6'h20;

  // Converter cycle states
  typedef enum logic [1:0] {
    ADCCR_POR = 2'b00,
    ADCCR_CONV = 2'b01,
    ADCCR_SLEEP = 2'b10,
    ADCCR_OUT = 2'b11
  } adccr_state_t;

endpackage : adccr_pkg

//--- bench/adccr_host.sv
// Host controller model: chip select, shift clock and selection word
`timescale 1ns/100ps
module adccr_host
(
  input wire logic i_ref_clk,
  input wire logic i_sck_line,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_cfg
);
  // Idle host: deselected, shift clock low
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_cfg = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step

  task automatic set_cs(input logic v);
    o_cs_n = v;
  endtask : set_cs

  task automatic set_cfg(input logic v);
    o_cfg = v;
  endtask : set_cfg

  // A released data line reads inverted, so a missed enable never passes
  task automatic read_word(input int nbits, input logic [3:0] sel, input bit clock_source_sel, output logic [31:0] word);
    int n;
    word = 'x;
    o_cs_n = 1'b0;
    step(8);
    for (int i = 0; i < nbits; i++)
    begin
      o_cfg = (i < 4) ? sel[3 - i] : 1'b0;
      if (clock_source_sel)
      begin
        step(6);
        word[31 - i] = i_sdo_oe ? i_sdo : ~i_sdo;
        o_sck = 1'b1;
        step(6);
        o_sck = 1'b0;
      end
      else
      begin
        for (n = 0; n < 200 && !i_sck_line; n++) step(1);
        word[31 - i] = i_sdo_oe ? i_sdo : ~i_sdo;
        for (n = 0; n < 200 && i_sck_line; n++) step(1);
      end
    end
    o_cfg = 1'b0;
  endtask : read_word
endmodule : adccr_host

//--- bench/tb_top.sv
// Self-checking bench for the converter cycle and serial readout block
`timescale 1ns/100ps
module tb_top
  import adccr_pkg::*;
;
  localparam int unsigned POR_SIM = 20;
  localparam int TICK = 7; // Conversion clock period in main cycles
  localparam logic [29:0] RES_A = 30'h2a5c3e1b;
  localparam logic [29:0] RES_B = 30'h15a3c1e4;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic src_sel = 1'b0;
  logic conv_clk = 1'b0;
  logic [29:0] conv_res = RES_A;
  logic cs_n, host_sck, cfg, sck, sck_oe, serial_result_out, sdo_oe, busy, calib, sck_line;
  logic [3:0] speed;
  logic [31:0] word;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0 = 0;

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Level on the two-way shift clock pin
  assign sck_line = sck_oe ? sck : host_sck;
  // External conversion clock; fast enough to keep the run short, inside its legal range
  always
  begin
    repeat (3) @(posedge ref_clk);
    #1 conv_clk = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 conv_clk = 1'b0;
  end

  adccr_ctrl #(.POR_LEN(POR_SIM)) i_dut (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_cs_n(cs_n),
    .i_serial_cfg_in(cfg), .i_clock_source_sel(src_sel), .i_conv_clock_pin(conv_clk), .i_sck(sck_line),
    .i_conv_result(conv_res), .o_sck(sck), .o_sck_oe(sck_oe), .o_serial_result_out(serial_result_out),
    .o_serial_result_oe(sdo_oe), .o_busy(busy), .o_calibrating(calib), .o_speed_sel(speed));
  adccr_host i_host (.i_ref_clk(ref_clk), .i_sck_line(sck_line), .i_sdo(serial_result_out), .i_sdo_oe(sdo_oe),
    .o_cs_n(cs_n), .o_sck(host_sck), .o_cfg(cfg));

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic miss(input string what);
    $display("MISMATCH %0t %s", $time, what);
    err_count++;
  endtask : miss

  task automatic check_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) miss(what);
  endtask : check_vec

  task automatic check_near(input int got, input int exp, input string what);
    total_checks++;
    if (got < exp - 24 || got > exp + 24) miss(what);
  endtask : check_near

  // Conversion length in main cycles for a speed index
  function automatic int conv_cycles(input int idx);
    return (40 * (64 << idx) + 170) * TICK;
  endfunction : conv_cycles

  task automatic wait_busy(input logic lvl, input int limit);
    int n;
    for (n = 0; n < limit && busy !== lvl; n++) step(1);
    check_vec({31'h0, busy}, {31'h0, lvl}, "busy wait");
  endtask : wait_busy

  task automatic test_reset;
    check_vec({31'h0, busy}, 32'h1, "busy in reset");
    check_vec({31'h0, sdo_oe}, 32'h0, "sdo enable in reset");
    check_vec({31'h0, sck_oe}, 32'h0, "shift clock not driven");
  endtask : test_reset

  // Fast setting, full external-clock read with a selection word
  task automatic test_first_read;
    wait_busy(1'b0, 90000);
    check_near(cyc - t0, POR_SIM + conv_cycles(2), "first conversion time");
    check_vec({28'h0, speed}, 32'h2, "level speed");
    i_host.set_cs(1'b0);
    step(4);
    check_vec({30'h0, sdo_oe, serial_result_out}, 32'h2, "done flag low");
    i_host.read_word(32, 4'h1, 1'b1, word);
    conv_res = RES_B;
    check_vec(word, {2'b00, RES_A}, "result word");
    step(6);
    t0 = cyc - 6;
    check_vec({30'h0, serial_result_out, busy}, 32'h3, "restart after last bit");
    step(4);
    check_vec({28'h0, speed}, 32'h0, "selected speed");
    i_host.set_cs(1'b1);
    step(4);
    check_vec({31'h0, sdo_oe}, 32'h0, "released line");
  endtask : test_first_read

  // Status during conversion, calibration span, internal shift clock, abort with level high
  task automatic test_status_abort;
    int n;
    int t1;
    src_sel = 1'b1;
    i_host.set_cs(1'b0);
    step(5);
    check_vec({27'h0, sck_oe, sdo_oe, serial_result_out, busy, calib}, 32'h1e, "status while converting");
    i_host.set_cs(1'b1);
    for (n = 0; n < 25000 && calib !== 1'b1; n++) step(1);
    t1 = cyc;
    wait_busy(1'b0, 25000);
    check_near(cyc - t0, conv_cycles(0), "second conversion time");
    check_near(cyc - t1, 170 * TICK, "calibration span");
    i_host.read_word(10, 4'h0, 1'b0, word);
    check_vec({word[31:22], 22'h0}, {2'b00, RES_B[29:22], 22'h0}, "internal clock bits");
    check_vec({31'h0, busy}, 32'h0, "busy low in output");
    step(1);
    i_host.set_cfg(1'b1);
    i_host.set_cs(1'b1);
    step(5);
    check_vec({30'h0, busy, sdo_oe}, 32'h2, "abort restarts");
    check_vec({28'h0, speed}, {28'h0, SPEED_QUIET}, "quiet level speed");
  endtask : test_status_abort

  // Watchdog a little past the expected run of about 93,000 cycles
  initial
  begin
    repeat (99000) @(posedge ref_clk);
    miss("watchdog");
    stop_test();
  end

  initial
  begin
    step(1);
    test_reset();
    step(2);
    reset_n = 1'b1;
    t0 = cyc;
    test_first_read();
    test_status_abort();
    stop_test();
  end
endmodule : tb_top
